// File: common/hsr_defs.vh
// register map, field positions and reset values of the status reporting block
`ifndef HSR_DEFS_VH
`define HSR_DEFS_VH
// register selects on the internal register port
`define HSR_SEL_SUMMARY 3'h0
`define HSR_SEL_SRQ_MASK 3'h1
`define HSR_SEL_STD_FLAGS 3'h2
`define HSR_SEL_STD_MASK 3'h3
`define HSR_SEL_LINK_FLAGS 3'h4
`define HSR_SEL_LINK_MASK 3'h5
`define HSR_SEL_OVL_FLAGS 3'h6
`define HSR_SEL_OVL_MASK 3'h7
// summary byte positions
`define HSR_SB_OVERLOAD 0
`define HSR_SB_IDLE 4
`define HSR_SB_STD_EVENT 5
`define HSR_SB_MASTER 6
`define HSR_SB_LINK_ERROR 7
// standard event flag positions
`define HSR_STD_OP_DONE 0
`define HSR_STD_RX_DISCARD 1
`define HSR_STD_REPLY_LOST 2
`define HSR_STD_DEFERRED 3
`define HSR_STD_RUN_FAULT 4
`define HSR_STD_PARSER_FAULT 5
`define HSR_STD_BUTTON 6
`define HSR_STD_POWER_UP 7
// link error flag positions
`define HSR_LNK_PARITY 0
`define HSR_LNK_FRAMING 1
`define HSR_LNK_NOISE 2
`define HSR_LNK_BYTE_LOST 3
`define HSR_LNK_OVERFLOW 4
`define HSR_LNK_DEV_CLEAR 7
// bits kept in the link flags (bits 5 and 6 unused)
`define HSR_LNK_USED 8'h9F
// service request mask writable bits (bit 6 fixed zero)
`define HSR_SRQ_WMASK 8'hBF
// reset values
`define HSR_MASK_RST 8'h00
`define HSR_FLAGS_RST 8'h00
`endif

// File: rtl/hsr_sticky_reg.v
// one eight-bit sticky event register with whole and single-bit read clear
`timescale 1ns/10ps
`default_nettype none
module hsr_sticky_reg #(
   parameter WIDTH = 8
) (
   input wire ref_clk_in,
   input wire rst_b_in,
   input wire [WIDTH-1:0] set_in,
   input wire clr_all_in,
   input wire clr_bit_in,
   input wire [2:0] bit_sel_in,
   input wire [WIDTH-1:0] keep_in,
   output reg [WIDTH-1:0] flags_out
);
   reg [WIDTH-1:0] clr_vec;
   reg [WIDTH-1:0] flags_d;

   // clear vector first, then set wins so a simultaneous event survives
   always @* begin
      clr_vec = {WIDTH{1'b0}};
      if (clr_all_in) begin
         clr_vec = {WIDTH{1'b1}};
      end else if (clr_bit_in) begin
         clr_vec[bit_sel_in] = 1'b1;
      end
      flags_d = ((flags_out & ~clr_vec) | set_in) & keep_in;
   end

   // flag storage
   always @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         flags_out <= {WIDTH{1'b0}};
      end else begin
         flags_out <= flags_d;
      end
   end
endmodule // hsr_sticky_reg
`default_nettype wire

// File: rtl/hsr_status_core.v
// hierarchical status reporting: event flags, masks, summary byte, service line
`timescale 1ns/10ps
`default_nettype none
`include "hsr_defs.vh"
module hsr_status_core #(
   parameter CHANNELS = 4
) (
   input wire ref_clk_in,
   input wire rst_b_in,
   // register port from the command parser
   input wire reg_wr_in,
   input wire reg_rd_in,
   input wire reg_bit_rd_in,
   input wire [2:0] reg_sel_in,
   input wire [2:0] reg_bit_in,
   input wire [7:0] reg_wdata_in,
   input wire clear_status_in,
   input wire summary_query_in,
   output reg [7:0] reg_rdata_out,
   // standard events
   input wire op_done_cmd_in,
   input wire rx_discard_in,
   input wire reply_lost_in,
   input wire deferred_fault_in,
   input wire run_fault_in,
   input wire parser_fault_in,
   input wire button_press_in,
   // parser state
   input wire rx_buffer_empty_in,
   input wire parser_busy_in,
   // receiver events
   input wire parity_err_in,
   input wire framing_err_in,
   input wire noise_err_in,
   input wire receiver_byte_lost_in,
   input wire rx_buffer_overflow_in,
   input wire serial_break_in,
   // channel events
   input wire [CHANNELS-1:0] channel_over_resistance_in,
   input wire [CHANNELS-1:0] curve_range_exceeded_in,
   // outputs
   output reg status_b_out,
   output reg rx_flush_out,
   output reg tx_flush_out,
   output reg parser_reset_out
);
   // masked OR of flags against enable
   function masked_any;
      input [7:0] flags;
      input [7:0] mask;
      begin
         masked_any = |(flags & mask);
      end
   endfunction

   // decodes a read-clear request for one event register
   function clr_hit;
      input rd;
      input [2:0] sel;
      input [2:0] mine;
      begin
         clr_hit = rd && (sel == mine);
      end
   endfunction

   reg [7:0] srq_mask_q;
   reg [7:0] std_mask_q;
   reg [7:0] link_mask_q;
   reg [7:0] ovl_mask_q;
   reg power_up_pend_q;
   reg [7:0] notified_q;
   reg [7:0] notified_d;
   reg status_b_d;
   wire [7:0] std_event_flags;
   wire [7:0] link_error_flags;
   wire [7:0] overload_flags;
   reg [7:0] std_set;
   reg [7:0] link_set;
   reg [7:0] ovl_set;
   wire idle_now;
   wire std_event_summary;
   wire link_error_summary;
   wire overload_summary;
   wire [7:0] sb_raw;
   wire master_summary;
   wire [7:0] summary_byte;
   wire [7:0] enabled_now;
   reg [7:0] rdata_d;

   // power-up event held until the first clocked cycle after reset
   always @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         power_up_pend_q <= 1'b1;
      end else begin
         power_up_pend_q <= 1'b0;
      end
   end

   // event set vectors
   always @* begin
      std_set = 8'h00;
      std_set[`HSR_STD_OP_DONE] = op_done_cmd_in;
      std_set[`HSR_STD_RX_DISCARD] = rx_discard_in;
      std_set[`HSR_STD_REPLY_LOST] = reply_lost_in;
      std_set[`HSR_STD_BUTTON] = button_press_in;
      std_set[`HSR_STD_POWER_UP] = power_up_pend_q;
      std_set[`HSR_STD_DEFERRED] = deferred_fault_in;
      std_set[`HSR_STD_RUN_FAULT] = run_fault_in;
      std_set[`HSR_STD_PARSER_FAULT] = parser_fault_in;
      link_set = 8'h00;
      link_set[`HSR_LNK_PARITY] = parity_err_in;
      link_set[`HSR_LNK_FRAMING] = framing_err_in;
      link_set[`HSR_LNK_NOISE] = noise_err_in;
      link_set[`HSR_LNK_BYTE_LOST] = receiver_byte_lost_in;
      link_set[`HSR_LNK_OVERFLOW] = rx_buffer_overflow_in;
      link_set[`HSR_LNK_DEV_CLEAR] = serial_break_in;
      ovl_set = {curve_range_exceeded_in[3:0], channel_over_resistance_in[3:0]};
   end

   hsr_sticky_reg #(
      .WIDTH(8)
   ) u_std_flags (
      .ref_clk_in(ref_clk_in),
      .rst_b_in(rst_b_in),
      .set_in(std_set),
      .clr_all_in(clear_status_in |
         clr_hit(reg_rd_in, reg_sel_in, `HSR_SEL_STD_FLAGS)),
      .clr_bit_in(clr_hit(reg_bit_rd_in, reg_sel_in, `HSR_SEL_STD_FLAGS)),
      .bit_sel_in(reg_bit_in),
      .keep_in(8'hFF),
      .flags_out(std_event_flags)
   );

   // link flags, bits 5 and 6 held at zero
   hsr_sticky_reg #(
      .WIDTH(8)
   ) u_link_flags (
      .ref_clk_in(ref_clk_in),
      .rst_b_in(rst_b_in),
      .set_in(link_set),
      .clr_all_in(clear_status_in |
         clr_hit(reg_rd_in, reg_sel_in, `HSR_SEL_LINK_FLAGS)),
      .clr_bit_in(clr_hit(reg_bit_rd_in, reg_sel_in, `HSR_SEL_LINK_FLAGS)),
      .bit_sel_in(reg_bit_in),
      .keep_in(`HSR_LNK_USED),
      .flags_out(link_error_flags)
   );

   hsr_sticky_reg #(
      .WIDTH(8)
   ) u_ovl_flags (
      .ref_clk_in(ref_clk_in),
      .rst_b_in(rst_b_in),
      .set_in(ovl_set),
      .clr_all_in(clear_status_in |
         clr_hit(reg_rd_in, reg_sel_in, `HSR_SEL_OVL_FLAGS)),
      .clr_bit_in(clr_hit(reg_bit_rd_in, reg_sel_in, `HSR_SEL_OVL_FLAGS)),
      .bit_sel_in(reg_bit_in),
      .keep_in(8'hFF),
      .flags_out(overload_flags)
   );

   // mask registers
   always @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         srq_mask_q <= `HSR_MASK_RST;
         std_mask_q <= `HSR_MASK_RST;
         link_mask_q <= `HSR_MASK_RST;
         ovl_mask_q <= `HSR_MASK_RST;
      end else if (reg_wr_in) begin
         case (reg_sel_in)
            `HSR_SEL_SRQ_MASK: srq_mask_q <= reg_wdata_in & `HSR_SRQ_WMASK;
            `HSR_SEL_STD_MASK: std_mask_q <= reg_wdata_in;
            `HSR_SEL_LINK_MASK: link_mask_q <= reg_wdata_in;
            `HSR_SEL_OVL_MASK: ovl_mask_q <= reg_wdata_in;
            default: srq_mask_q <= srq_mask_q;
         endcase
      end
   end

   // summaries straight from current flags and masks
   assign std_event_summary = masked_any(std_event_flags, std_mask_q);
   assign link_error_summary = masked_any(link_error_flags, link_mask_q);
   assign overload_summary = masked_any(overload_flags, ovl_mask_q);
   assign idle_now = rx_buffer_empty_in & ~parser_busy_in;
   // summary byte layout without master bit
   assign sb_raw = {link_error_summary, 1'b0, std_event_summary, idle_now,
      3'b000, overload_summary};
   // master bit; srq mask bit 6 is always zero so no loop
   assign master_summary = masked_any(sb_raw, srq_mask_q);
   // the query never touches these bits
   assign summary_byte = sb_raw | (master_summary ? 8'h40 : 8'h00);
   assign enabled_now = sb_raw & srq_mask_q;

   // service line: a bit enabled now but not yet reported drives it low
   always @* begin
      notified_d = notified_q & enabled_now;
      status_b_d = status_b_out;
      if (summary_query_in) begin
         notified_d = enabled_now;
         status_b_d = 1'b1;
      end
      // only a fresh enabled bit reasserts
      if (|(enabled_now & ~notified_q) && !summary_query_in) begin
         status_b_d = 1'b0;
      end
   end

   // service line and reported-bit memory
   always @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         notified_q <= 8'h00;
         status_b_out <= 1'b1;
      end else begin
         notified_q <= notified_d;
         status_b_out <= status_b_d;
      end
   end

   // read data mux; flags shown before the read clears them
   always @* begin
      case (reg_sel_in)
         `HSR_SEL_SUMMARY: rdata_d = summary_byte;
         `HSR_SEL_SRQ_MASK: rdata_d = srq_mask_q;
         `HSR_SEL_STD_FLAGS: rdata_d = std_event_flags;
         `HSR_SEL_STD_MASK: rdata_d = std_mask_q;
         `HSR_SEL_LINK_FLAGS: rdata_d = link_error_flags;
         `HSR_SEL_LINK_MASK: rdata_d = link_mask_q;
         `HSR_SEL_OVL_FLAGS: rdata_d = overload_flags;
         `HSR_SEL_OVL_MASK: rdata_d = ovl_mask_q;
         default: rdata_d = 8'h00;
      endcase
      if (reg_bit_rd_in) begin
         rdata_d = {7'b000_0000, rdata_d[reg_bit_in]};
      end
   end

   // registered read data and flush pulses
   always @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         reg_rdata_out <= 8'h00;
         rx_flush_out <= 1'b0;
         tx_flush_out <= 1'b0;
         parser_reset_out <= 1'b0;
      end else begin
         if (reg_rd_in || reg_bit_rd_in || summary_query_in) begin
            reg_rdata_out <= summary_query_in ? summary_byte : rdata_d;
         end
         rx_flush_out <= receiver_byte_lost_in | rx_buffer_overflow_in | serial_break_in;
         parser_reset_out <= receiver_byte_lost_in | rx_buffer_overflow_in | serial_break_in;
         tx_flush_out <= serial_break_in;
      end
   end
endmodule // hsr_status_core
`default_nettype wire

// File: dv/hsr_status_checker_assertions.sv
// port-level assertions for the status reporting block
`timescale 1ns/10ps
`default_nettype none
`include "hsr_defs.vh"
module hsr_status_checker (
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   input wire logic reg_rd_in,
   input wire logic [2:0] reg_sel_in,
   input wire logic summary_query_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic rx_buffer_empty_in,
   input wire logic parser_busy_in,
   input wire logic receiver_byte_lost_in,
   input wire logic rx_buffer_overflow_in,
   input wire logic serial_break_in,
   input wire logic status_b_out,
   input wire logic rx_flush_out,
   input wire logic tx_flush_out,
   input wire logic parser_reset_out
);
   // one clock domain, so clocking and disable are shared
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_b_in);
   a_lost_byte_flush: assert property (receiver_byte_lost_in |=> rx_flush_out && parser_reset_out)
      else $error("no flush after lost byte");
   a_overflow_flush: assert property (rx_buffer_overflow_in |=> rx_flush_out && parser_reset_out)
      else $error("no flush after overflow");
   a_break_flush: assert property (serial_break_in |=> tx_flush_out && rx_flush_out && parser_reset_out)
      else $error("no flush after break");
   a_tx_flush_cause: assert property (tx_flush_out |-> $past(serial_break_in))
      else $error("output flush without break");
   a_query_release: assert property (summary_query_in |=> status_b_out)
      else $error("service line not released");
   a_line_holds_low: assert property (!status_b_out && !summary_query_in |=> !status_b_out)
      else $error("service line rose without query");
   a_srq_bit_zero: assert property (reg_rd_in && reg_sel_in == `HSR_SEL_SRQ_MASK |=> !reg_rdata_out[6])
      else $error("service mask bit 6 not zero");
   a_summary_gap_zero: assert property (summary_query_in |=> reg_rdata_out[3:1] == 3'h0)
      else $error("summary bits 1 to 3 not zero");
   // idle is sampled at the query edge
   a_idle_bit: assert property (summary_query_in |=>
      reg_rdata_out[4] == ($past(rx_buffer_empty_in) && !$past(parser_busy_in)))
      else $error("idle bit wrong");
   a_link_gap_zero: assert property (reg_rd_in && reg_sel_in == `HSR_SEL_LINK_FLAGS |=> reg_rdata_out[6:5] == 2'h0)
      else $error("unused link bits not zero");
endmodule // hsr_status_checker
bind hsr_status_core hsr_status_checker u_chk (.ref_clk_in, .rst_b_in, .reg_rd_in, .reg_sel_in,
   .summary_query_in, .reg_rdata_out, .rx_buffer_empty_in, .parser_busy_in,
   .receiver_byte_lost_in, .rx_buffer_overflow_in, .serial_break_in, .status_b_out,
   .rx_flush_out, .tx_flush_out, .parser_reset_out);
`default_nettype wire

// File: dv/hsr_host_model.sv
// host that answers the service line with a summary query
`timescale 1ns/10ps
`default_nettype none
module hsr_host_model (
   input wire logic ref_clk_in,
   input wire logic rst_b_in,
   input wire logic status_b_out,
   input wire logic [7:0] reg_rdata_out,
   input wire logic en_in,
   input wire logic [3:0] delay_in,
   output logic query_out,
   output logic [7:0] seen_out,
   output logic [7:0] served_out
);
   logic [3:0] cnt_q;
   logic busy_q, grab_q;
   // wait delay_in cycles, query once, take the byte a cycle later
   always @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         query_out <= 1'b0;
         busy_q <= 1'b0;
         grab_q <= 1'b0;
         cnt_q <= 4'h0;
         seen_out <= 8'h00;
         served_out <= 8'h00;
      end else begin
         query_out <= 1'b0;
         grab_q <= query_out;
         if (grab_q) begin
            seen_out <= reg_rdata_out;
            served_out <= served_out + 8'h01;
         end
         if (busy_q && cnt_q == 4'h0) begin
            query_out <= 1'b1;
            busy_q <= 1'b0;
         end else if (busy_q) begin
            cnt_q <= cnt_q - 4'h1;
         end else if (en_in && !status_b_out && !query_out && !grab_q) begin
            busy_q <= 1'b1;
            cnt_q <= delay_in;
         end
      end
   end
endmodule // hsr_host_model
`default_nettype wire

// File: dv/hierarchical_status_reporting_test.sv
// self-checking bench for the status reporting block
`timescale 1ns/10ps
`default_nettype none
module hierarchical_status_reporting_test;
   localparam logic [3:0] Q = 4'h8, W = 4'h4, R = 4'h2, B = 4'h1;
   logic ref_clk_in = 1'b0, rst_b_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
   logic reg_bit_rd_in = 1'b0, clear_status_in = 1'b0, tb_query = 1'b0, host_en = 1'b0;
   logic rx_buffer_empty_in = 1'b1, parser_busy_in = 1'b0;
   logic [2:0] reg_sel_in = 3'h0, reg_bit_in = 3'h0;
   logic [7:0] reg_wdata_in = 8'h00, ovl = 8'h00;
   logic [6:0] std_ev = 7'h00;
   logic [5:0] lnk_ev = 6'h00;
   logic [3:0] host_delay = 4'h5;
   wire [7:0] reg_rdata_out, host_seen, host_served;
   wire status_b_out, rx_flush_out, tx_flush_out, parser_reset_out, host_query;
   wire summary_query_in;
   int miscompares = 0, cmp_count = 0;
   // host and bench share the query strobe
   assign summary_query_in = tb_query | host_query;
   hsr_status_core #(.CHANNELS(4)) dut (.ref_clk_in, .rst_b_in, .reg_wr_in, .reg_rd_in,
      .reg_bit_rd_in, .reg_sel_in, .reg_bit_in, .reg_wdata_in, .clear_status_in,
      .summary_query_in, .reg_rdata_out, .op_done_cmd_in(std_ev[0]), .rx_discard_in(std_ev[1]),
      .reply_lost_in(std_ev[2]), .deferred_fault_in(std_ev[3]), .run_fault_in(std_ev[4]),
      .parser_fault_in(std_ev[5]), .button_press_in(std_ev[6]), .rx_buffer_empty_in,
      .parser_busy_in, .parity_err_in(lnk_ev[0]), .framing_err_in(lnk_ev[1]),
      .noise_err_in(lnk_ev[2]), .receiver_byte_lost_in(lnk_ev[3]),
      .rx_buffer_overflow_in(lnk_ev[4]), .serial_break_in(lnk_ev[5]),
      .channel_over_resistance_in(ovl[3:0]), .curve_range_exceeded_in(ovl[7:4]),
      .status_b_out, .rx_flush_out, .tx_flush_out, .parser_reset_out);
   hsr_host_model host (.ref_clk_in, .rst_b_in, .status_b_out, .reg_rdata_out, .en_in(host_en),
      .delay_in(host_delay), .query_out(host_query), .seen_out(host_seen),
      .served_out(host_served));
   // 10 MHz clock
   always #50 ref_clk_in = ~ref_clk_in;
   task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one register port request, held until the edge that takes it
   task req(input logic [3:0] k, input logic [2:0] s, input logic [7:0] d, input logic [2:0] b);
      @(posedge ref_clk_in);
      {tb_query, reg_wr_in, reg_rd_in, reg_bit_rd_in} <= k;
      reg_sel_in <= s;
      reg_wdata_in <= d;
      reg_bit_in <= b;
      @(posedge ref_clk_in);
      {tb_query, reg_wr_in, reg_rd_in, reg_bit_rd_in} <= 4'h0;
      #10;
   endtask
   task rd(input logic [3:0] k, input logic [2:0] s, input logic [2:0] b, input logic [7:0] e);
      req(k, s, 8'h00, b);
      check("read data", reg_rdata_out, e);
   endtask
   // query the summary byte; the line must be released after it
   task query(input logic [7:0] e);
      rd(Q, 3'h0, 3'h0, e);
      check("line after query", status_b_out, 8'h01);
      // already reported bits must not pull the line low again
      @(posedge ref_clk_in);
      #10;
      check("line stays high", status_b_out, 8'h01);
   endtask
   // one-cycle event pulse, returns once the line could have fallen
   task pulse(input logic [6:0] s, input logic [5:0] l, input logic [7:0] o);
      @(posedge ref_clk_in);
      std_ev <= s;
      lnk_ev <= l;
      ovl <= o;
      @(posedge ref_clk_in);
      std_ev <= 7'h00;
      lnk_ev <= 6'h00;
      ovl <= 8'h00;
      @(posedge ref_clk_in);
      #10;
   endtask
   task wait_host(input logic [7:0] n);
      for (int t = 0; t < 50 && host_served != n; t++) @(posedge ref_clk_in);
      #10;
      check("host answers", host_served, n);
      check("host summary", host_seen, 8'h41);
   endtask
   task complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // a hang costs far more than the few hundred cycles of the run
   initial begin
      #400_000;
      miscompares++;
      complete_run;
   end
   // main sequence
   initial begin
      repeat (5) @(posedge ref_clk_in);
      rst_b_in <= 1'b1;
      for (int i = 1; i < 8; i += 2) rd(R, 3'(i), 3'h0, 8'h00);
      rd(R, 3'h2, 3'h0, 8'h80);
      for (int i = 0; i < 7; i++) begin
         pulse(7'(1 << i), 6'h00, 8'h00);
         rd(R, 3'h2, 3'h0, 8'(1 << i));
      end
      for (int i = 0; i < 6; i++) begin
         pulse(7'h00, 6'(1 << i), 8'h00);
         rd(R, 3'h4, 3'h0, (i == 5) ? 8'h80 : 8'(1 << i));
      end
      for (int i = 0; i < 8; i++) begin
         pulse(7'h00, 6'h00, 8'(1 << i));
         rd(R, 3'h6, 3'h0, 8'(1 << i));
      end
      pulse(7'h7F, 6'h00, 8'h00);
      rd(B, 3'h2, 3'h3, 8'h01);
      rd(B, 3'h2, 3'h3, 8'h00);
      rd(R, 3'h2, 3'h0, 8'h77);
      pulse(7'h01, 6'h01, 8'h01);
      @(posedge ref_clk_in) clear_status_in <= 1'b1;
      @(posedge ref_clk_in) clear_status_in <= 1'b0;
      for (int i = 2; i < 8; i += 2) rd(R, 3'(i), 3'h0, 8'h00);
      for (int i = 3; i < 8; i += 2) req(W, 3'(i), 8'h01, 3'h0);
      req(W, 3'h1, 8'hFF, 3'h0);
      rd(R, 3'h1, 3'h0, 8'hBF);
      check("line", status_b_out, 8'h00);
      query(8'h50);
      query(8'h50);
      rd(R, 3'h0, 3'h0, 8'h50);
      @(posedge ref_clk_in) parser_busy_in <= 1'b1;
      query(8'h00);
      // parser idle but bytes waiting: still not idle
      @(posedge ref_clk_in) {parser_busy_in, rx_buffer_empty_in} <= 2'b00;
      query(8'h00);
      pulse(7'h01, 6'h00, 8'h00);
      check("line", status_b_out, 8'h00);
      query(8'h60);
      pulse(7'h00, 6'h01, 8'h00);
      check("line", status_b_out, 8'h00);
      query(8'hE0);
      pulse(7'h00, 6'h00, 8'h01);
      query(8'hE1);
      req(W, 3'h3, 8'h00, 3'h0);
      query(8'hC1);
      rd(R, 3'h4, 3'h0, 8'h01);
      query(8'h41);
      rd(B, 3'h6, 3'h0, 8'h01);
      query(8'h00);
      pulse(7'h00, 6'h00, 8'h02);
      query(8'h00);
      @(posedge ref_clk_in) host_en <= 1'b1;
      pulse(7'h00, 6'h00, 8'h01);
      wait_host(8'h01);
      rd(B, 3'h6, 3'h0, 8'h01);
      @(posedge ref_clk_in) host_delay <= 4'h0;
      pulse(7'h00, 6'h00, 8'h01);
      wait_host(8'h02);
      complete_run;
   end
endmodule // hierarchical_status_reporting_test
`default_nettype wire
